// file: common/mrm_pkg.sv
/*
 Shared constants, types and decode functions for the multiport register
 map: global and per-port offsets, field positions, timing counts.
 Assumes an 11-bit word address with bit 0 as byte select in 8-bit mode.
*/
package mrm_pkg;
	localparam int ADDR_W = 11;
	localparam int DATA_W = 16;
	localparam int MAX_PORTS = 4;
	localparam int NLAT = 4;
	localparam int NEV = 3;
	localparam int NCNT = 2;
	localparam int CNT_W = 16;
	// Global offsets, port 0 low slice
	localparam logic [8:0] GL_CR_OFF = 9'h002;
	localparam logic [8:0] GL_SR_OFF = 9'h014;
	localparam logic [8:0] GL_UNUSED_LO = 9'h020;
	localparam logic [8:0] GL_SYS_LO = 9'h030;
	// Per-port sub-block windows
	localparam logic [8:0] W_COMMON_LO = 9'h040;
	localparam logic [8:0] W_BERT_LO = 9'h060;
	localparam logic [8:0] W_RSV_LO = 9'h080;
	localparam logic [8:0] W_LENC_LO = 9'h08C;
	localparam logic [8:0] W_LDEC_LO = 9'h090;
	localparam logic [8:0] W_HDLC_LO = 9'h0A0;
	// Per-port registers
	localparam logic [8:0] P_CFG_OFF = 9'h040;
	localparam logic [8:0] P_PSR_OFF = 9'h052;
	localparam logic [8:0] P_LSR_OFF = 9'h054;
	localparam logic [8:0] P_LIE_OFF = 9'h056;
	localparam logic [8:0] P_CNT0_OFF = 9'h09C;
	localparam logic [8:0] P_CNT1_OFF = 9'h09E;
	localparam logic [1:0] PORT_NO_LOW = 2'h3;
	// Field positions and masks
	localparam int CFG_ACT_BIT = 0;
	localparam int CFG_MODE_BIT = 1;
	localparam int GCR_WCLR_BIT = 2;
	localparam int LS_EV1_BIT = 1;
	localparam logic [15:0] M_ALL = 16'hFFFF;
	localparam logic [15:0] M_LAT = 16'h000F;
	localparam logic [15:0] M_PSR = 16'h0007;
	localparam logic [15:0] M_GSR = 16'h0001;
	localparam logic [15:0] M_NONE = 16'h0000;
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int RDY_TIMEOUT_NS = 40;
	localparam int RDY_TO_CYC = RDY_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int UPD_TIMEOUT_NS = 100;
	localparam int UPD_TO_CYC = UPD_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int UPD_SETTLE_CYC = 2;

	typedef enum logic [2:0] {BLK_NONE, BLK_COMMON, BLK_BERT, BLK_RSV,
		BLK_LENC, BLK_LDEC, BLK_OTHER} mrm_blk_e;

	// Sub-block window of a port-relative offset
	function automatic mrm_blk_e blk_of(input logic [8:0] off);
		if (off < W_COMMON_LO) blk_of = BLK_NONE;
		else if (off < W_BERT_LO) blk_of = BLK_COMMON;
		else if (off < W_RSV_LO) blk_of = BLK_BERT;
		else if (off < W_LENC_LO) blk_of = BLK_RSV;
		else if (off < W_LDEC_LO) blk_of = BLK_LENC;
		else if (off < W_HDLC_LO) blk_of = BLK_LDEC;
		else blk_of = BLK_OTHER;
	endfunction

	// Location owned by some block (ready handshake given)
	function automatic logic map_ok(input logic [10:0] a, input int np);
		logic [1:0] pt;
		pt = a[10:9];
		if (a[8:0] >= W_COMMON_LO) map_ok = (int'(pt) < np);
		else if (pt == 2'h0) map_ok = (a[8:0] < GL_UNUSED_LO) ||
			(a[8:0] >= GL_SYS_LO);
		else map_ok = (pt != PORT_NO_LOW);
	endfunction

	// Assigned bits of a register, word address
	function automatic logic [15:0] wmask(input logic [10:0] a);
		logic [8:0] off;
		off = {a[8:1], 1'b0};
		if (a[10:9] == 2'h0 && off == GL_CR_OFF) wmask = M_ALL;
		else if (a[10:9] == 2'h0 && off == GL_SR_OFF) wmask = M_GSR;
		else if (off == P_CFG_OFF) wmask = M_ALL;
		else if (off == P_PSR_OFF) wmask = M_PSR;
		else if (off == P_LSR_OFF || off == P_LIE_OFF) wmask = M_LAT;
		else if (off == P_CNT0_OFF || off == P_CNT1_OFF) wmask = M_ALL;
		else wmask = M_NONE;
	endfunction
endpackage

// file: common/mrm_link_if.sv
/*
 Parallel register bus between host and device, with update and reset
 lines. Both ends run on the same mclk.
*/
`timescale 1ns/10ps
interface mrm_link_if;
	logic [10:0] addr;
	logic [15:0] wdata;
	logic rd;
	logic wr;
	logic bus16;
	logic [15:0] rdata;
	logic rdy;
	logic datapath_reset_n;
	logic perf_update_strobe;
	logic perf_update_status;
	logic irq;
	modport dev (input addr, wdata, rd, wr, bus16, datapath_reset_n,
		perf_update_strobe, output rdata, rdy, perf_update_status, irq);
	modport hst (output addr, wdata, rd, wr, bus16, datapath_reset_n,
		perf_update_strobe, input rdata, rdy, perf_update_status, irq);
endinterface

// file: core/mrm_sat_cnt.sv
/*
 Saturating event counter with a counter register loaded on update.
 Assumes inc, load and clr come from logic on mclk.
*/
`timescale 1ns/10ps
module mrm_sat_cnt #(
	parameter int W = 16
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic inc,
	input wire logic load,
	input wire logic clr,
	output logic [W-1:0] count
);
	typedef struct packed {
		logic [W-1:0] live;
		logic [W-1:0] hold;
	} mrm_cnt_s;
	mrm_cnt_s s_r;
	mrm_cnt_s s_nxt;
	logic at_max;

	// Count, load and clear
	always_comb
	begin
		s_nxt = s_r;
		at_max = &s_r.live;
		if (clr)
		begin
			s_nxt = '0;
		end
		else if (load)
		begin
			s_nxt.hold = s_r.live;
			s_nxt.live = {{(W-1){1'b0}}, inc};
		end
		else if (inc && !at_max)
		begin
			s_nxt.live = s_r.live + {{(W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!nrst) s_r <= '0;
		else if (ce) s_r <= s_nxt;
	end

	assign count = s_r.hold;
endmodule

// file: core/mrm_dev.sv
/*
 Device end of the register map: address decode, per-port control,
 latched status, interrupt enables, counters and the update sequence.
 Assumes the host keeps to one strobe per cycle; events come from mclk.
*/
`timescale 1ns/10ps
// Notes on behaviour
// - Decode eleven-bit map, 000 to 7FF
// - Top address bit unused below three ports
// - Disabled banks ignore writes, read zero
// - Global reset restores every register default
// - Host writes zero to unassigned bits
// - Config changes stored, applied whenever data path reset is off
// - Counters stop at maximum, never wrap
// - Update on rising edge; status low meanwhile
// - Load, clear live, zero low, then status
// - Latched bit sets on event onset only
// - Change bit sets on onset and end
// - Read clear: sixteen or eight accessed bits
// - Write clear: ones clear, zeros keep
// - Reserved config stored; reserved status zero
// - Reserved latched never set; enables still work
// - Reserved counters frozen; updates still work
// - Data path reset after mode change clears
// - Host clears counters with two updates
// - Ports at 040-1FF of each slice
// - Absent ports drop writes, read zero
// - No ready for absent or unassigned space
// - Decode per-port sub-block windows
module mrm_dev #(
	parameter int NUM_PORTS = 4,
	parameter int CNT_W = 16
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ce,
	mrm_link_if.dev bus,
	input wire logic [3:0][2:0] port_evt,
	input wire logic [3:0][1:0] cnt_evt,
	output logic [3:0][15:0] port_cfg,
	output logic zero_count
);
	typedef enum logic [1:0] {S_IDLE, S_LOAD, S_ZERO} mrm_upd_e;
	typedef struct packed {
		logic [15:0] gcr;
		logic [3:0][15:0] cfg;
		logic [3:0][15:0] app;
		logic [3:0] act_prev;
		logic [3:0][3:0] lat;
		logic [3:0][3:0] lie;
		logic [3:0][2:0] evp;
		logic [3:0] mchg;
		mrm_upd_e st;
		logic upd_prev;
		logic pms;
		logic [15:0] rdata;
		logic rdy;
		logic irq;
		logic zero;
	} mrm_dev_s;
	mrm_dev_s s_r;
	mrm_dev_s s_nxt;
	logic [3:0][1:0][CNT_W-1:0] cnt_val;
	logic [3:0][1:0] cnt_inc;
	logic [3:0] cnt_clr;
	logic cnt_load;
	logic [10:0] a;
	logic [1:0] pt;
	logic [8:0] off;
	logic [1:0] be;
	logic [15:0] bmask;
	logic [15:0] word;
	logic ok;
	logic dp_on;
	logic trig;
	logic [3:0] set_l;
	logic [3:0] clr_l;
	logic any_nz;
	mrm_pkg::mrm_blk_e blk;

	// Merge write data into enabled bytes
	function automatic logic [15:0] bw(input logic [15:0] old,
		input logic [15:0] nw, input logic [15:0] m);
		bw = (old & ~m) | (nw & m);
	endfunction

	// Counters, one pair per present port
	genvar gp, gk;
	generate
		for (gp = 0; gp < mrm_pkg::MAX_PORTS; gp++)
		begin : g_port
			for (gk = 0; gk < mrm_pkg::NCNT; gk++)
			begin : g_cnt
				if (gp < NUM_PORTS)
				begin : g_on
					mrm_sat_cnt #(.W(CNT_W)) u_cnt (
						.mclk(mclk),
						.nrst(nrst),
						.ce(ce),
						.inc(cnt_inc[gp][gk]),
						.load(cnt_load),
						.clr(cnt_clr[gp]),
						.count(cnt_val[gp][gk])
					);
				end
				else
				begin : g_off
					assign cnt_val[gp][gk] = '0;
				end
			end
		end
	endgenerate

	// Decode, register access, status and update sequence
	always_comb
	begin
		s_nxt = s_r;
		dp_on = bus.datapath_reset_n;
		a = (NUM_PORTS < 3) ? {1'b0, bus.addr[9:0]} : bus.addr;
		pt = a[10:9];
		off = {a[8:1], 1'b0};
		blk = mrm_pkg::blk_of(off);
		ok = mrm_pkg::map_ok(a, NUM_PORTS);
		be = bus.bus16 ? 2'h3 : (a[0] ? 2'h2 : 2'h1);
		bmask = {{8{be[1]}}, {8{be[0]}}};
		word = '0;
		cnt_load = (s_r.st == S_LOAD);
		cnt_clr = '0;
		cnt_inc = '0;
		trig = bus.perf_update_strobe && !s_r.upd_prev;
		any_nz = 1'b0;
		set_l = '0;
		clr_l = '0;
		s_nxt.upd_prev = bus.perf_update_strobe;
		// Global registers
		if (pt == 2'h0 && off == mrm_pkg::GL_CR_OFF)
		begin
			word = s_r.gcr;
			if (bus.wr) s_nxt.gcr = bw(s_r.gcr, bus.wdata, bmask);
		end
		else if (pt == 2'h0 && off == mrm_pkg::GL_SR_OFF)
		begin
			word = {15'h0000, s_r.pms};
		end
		for (int p = 0; p < mrm_pkg::MAX_PORTS; p++)
		begin
			if (p < NUM_PORTS)
			begin
				// Applied config follows only outside data path reset
				if (dp_on) s_nxt.app[p] = s_r.cfg[p];
				s_nxt.act_prev[p] = s_r.cfg[p][mrm_pkg::CFG_ACT_BIT];
				if (dp_on && s_r.cfg[p][mrm_pkg::CFG_ACT_BIT] &&
					!s_r.act_prev[p]) trig = 1'b1;
				if (dp_on && s_r.cfg[p][mrm_pkg::CFG_MODE_BIT] !=
					s_r.app[p][mrm_pkg::CFG_MODE_BIT])
					s_nxt.mchg[p] = 1'b1;
				s_nxt.evp[p] = port_evt[p];
				set_l = '0;
				set_l[0] = port_evt[p][0] && !s_r.evp[p][0];
				set_l[1] = port_evt[p][1] && !s_r.evp[p][1] &&
					!s_r.app[p][mrm_pkg::CFG_MODE_BIT];
				set_l[2] = port_evt[p][2] != s_r.evp[p][2];
				cnt_inc[p][0] = cnt_evt[p][0];
				cnt_inc[p][1] = cnt_evt[p][1] &&
					!s_r.app[p][mrm_pkg::CFG_MODE_BIT];
				clr_l = '0;
				if (pt == 2'(p) && blk == mrm_pkg::BLK_COMMON)
				begin
					if (off == mrm_pkg::P_CFG_OFF)
					begin
						word = s_r.cfg[p];
						if (bus.wr)
							s_nxt.cfg[p] = bw(s_r.cfg[p], bus.wdata, bmask);
					end
					else if (off == mrm_pkg::P_PSR_OFF)
					begin
						word = {13'h0000, port_evt[p][2],
							port_evt[p][1] && !s_r.app[p][mrm_pkg::CFG_MODE_BIT],
							port_evt[p][0]};
					end
					else if (off == mrm_pkg::P_LSR_OFF)
					begin
						word = {12'h000, s_r.lat[p]};
						if (s_r.gcr[mrm_pkg::GCR_WCLR_BIT] && bus.wr)
							clr_l = bus.wdata[3:0] & bmask[3:0];
						else if (!s_r.gcr[mrm_pkg::GCR_WCLR_BIT] && bus.rd)
							clr_l = bmask[3:0];
					end
					else if (off == mrm_pkg::P_LIE_OFF)
					begin
						word = {12'h000, s_r.lie[p]};
						if (bus.wr) s_nxt.lie[p] = (s_r.lie[p] & ~bmask[3:0]) |
							(bus.wdata[3:0] & bmask[3:0]);
					end
				end
				else if (pt == 2'(p) && blk == mrm_pkg::BLK_LDEC)
				begin
					if (off == mrm_pkg::P_CNT0_OFF)
						word = 16'(cnt_val[p][0]);
					else if (off == mrm_pkg::P_CNT1_OFF)
						word = 16'(cnt_val[p][1]);
				end
				// Set wins over clear
				s_nxt.lat[p] = (s_r.lat[p] & ~clr_l) | set_l;
				// Clear after a mode change once data path reset is seen
				if (!dp_on && s_r.mchg[p])
				begin
					s_nxt.lat[p] = '0;
					s_nxt.mchg[p] = 1'b0;
					cnt_clr[p] = 1'b1;
				end
				if (|cnt_val[p]) any_nz = 1'b1;
			end
		end
		// Update sequence: load, zero pulse, status
		case (s_r.st)
			S_IDLE:
			begin
				if (trig)
				begin
					s_nxt.st = S_LOAD;
					s_nxt.pms = 1'b0;
				end
			end
			S_LOAD:
			begin
				s_nxt.st = S_ZERO;
			end
			default:
			begin
				s_nxt.st = S_IDLE;
				s_nxt.pms = 1'b1;
			end
		endcase
		s_nxt.zero = (s_nxt.st == S_ZERO) ? 1'b0 : !any_nz;
		s_nxt.irq = 1'b0;
		for (int p = 0; p < mrm_pkg::MAX_PORTS; p++)
			if (|(s_r.lat[p] & s_r.lie[p])) s_nxt.irq = 1'b1;
		// Answer one cycle after a strobe on mapped space only
		s_nxt.rdy = (bus.rd || bus.wr) && ok;
		if (!ok) word = '0;
		s_nxt.rdata = bus.bus16 ? word :
			(a[0] ? {8'h00, word[15:8]} : {8'h00, word[7:0]});
		if (!bus.rd) s_nxt.rdata = '0;
	end

	// Global reset restores all defaults
	always_ff @(posedge mclk)
	begin
		if (!nrst) s_r <= '0;
		else if (ce) s_r <= s_nxt;
	end

	assign bus.rdata = s_r.rdata;
	assign bus.rdy = s_r.rdy;
	assign bus.perf_update_status = s_r.pms;
	assign bus.irq = s_r.irq;
	assign port_cfg = s_r.app;
	assign zero_count = s_r.zero;
endmodule

// file: core/mrm_host.sv
/*
 Host end: turns user commands into bus strobes, waits for ready with a
 timeout, issues counter updates and replays the last write after data path reset.
*/
`timescale 1ns/10ps
module mrm_host #(
	parameter int NUM_PORTS = 4
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ce,
	mrm_link_if.hst bus,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [10:0] cmd_addr,
	input wire logic [15:0] cmd_wdata,
	input wire logic bus16_sel,
	input wire logic dp_reset_req,
	input wire logic upd_req,
	input wire logic clr_cnt_req,
	output logic cmd_ready,
	output logic resp_valid,
	output logic [15:0] resp_rdata,
	output logic resp_err
);
	typedef enum logic [1:0] {H_IDLE, H_WAIT, H_UPD, H_UWAIT} mrm_hst_e;
	typedef struct packed {
		mrm_hst_e st;
		logic [10:0] addr;
		logic [15:0] wdata;
		logic rd;
		logic wr;
		logic bus16;
		logic dpn;
		logic upd;
		logic [3:0] tmo;
		logic [1:0] upd_left;
		logic rep;
		logic shv;
		logic [10:0] sh_addr;
		logic [15:0] sh_data;
		logic ready;
		logic rv;
		logic [15:0] rdata;
		logic err;
	} mrm_hst_s;
	mrm_hst_s s_r;
	mrm_hst_s s_nxt;
	logic [10:0] ca;

	// Command sequencing
	always_comb
	begin
		s_nxt = s_r;
		ca = (NUM_PORTS < 3) ? {1'b0, cmd_addr[9:0]} : cmd_addr;
		s_nxt.rd = 1'b0;
		s_nxt.wr = 1'b0;
		s_nxt.rv = 1'b0;
		s_nxt.bus16 = bus16_sel;
		s_nxt.dpn = !dp_reset_req;
		if (!s_r.dpn && !dp_reset_req && s_r.shv) s_nxt.rep = 1'b1;
		case (s_r.st)
			H_IDLE:
			begin
				s_nxt.tmo = '0;
				if (s_r.rep)
				begin
					s_nxt.rep = 1'b0;
					s_nxt.addr = s_r.sh_addr;
					s_nxt.wdata = s_r.sh_data;
					s_nxt.wr = 1'b1;
					s_nxt.st = H_WAIT;
				end
				else if (cmd_valid)
				begin
					s_nxt.addr = ca;
					s_nxt.wdata = cmd_wdata & mrm_pkg::wmask(ca);
					s_nxt.wr = cmd_write;
					s_nxt.rd = !cmd_write;
					s_nxt.st = H_WAIT;
					if (cmd_write)
					begin
						s_nxt.shv = 1'b1;
						s_nxt.sh_addr = ca;
						s_nxt.sh_data = cmd_wdata & mrm_pkg::wmask(ca);
					end
				end
				else if (clr_cnt_req || upd_req)
				begin
					s_nxt.upd_left = clr_cnt_req ? 2'h2 : 2'h1;
					s_nxt.st = H_UPD;
				end
			end
			H_WAIT:
			begin
				s_nxt.tmo = s_r.tmo + 4'h1;
				if (bus.rdy)
				begin
					s_nxt.rv = 1'b1;
					s_nxt.err = 1'b0;
					s_nxt.rdata = bus.rdata & mrm_pkg::wmask(s_r.addr);
					s_nxt.st = H_IDLE;
				end
				else if (s_r.tmo == 4'(mrm_pkg::RDY_TO_CYC - 1))
				begin
					s_nxt.rv = 1'b1;
					s_nxt.err = 1'b1;
					s_nxt.rdata = '0;
					s_nxt.st = H_IDLE;
				end
			end
			H_UPD:
			begin
				s_nxt.tmo = '0;
				s_nxt.st = H_UWAIT;
			end
			default:
			begin
				s_nxt.tmo = s_r.tmo + 4'h1;
				if (s_r.tmo >= 4'(mrm_pkg::UPD_SETTLE_CYC) &&
					bus.perf_update_status)
				begin
					s_nxt.upd_left = s_r.upd_left - 2'h1;
					if (s_r.upd_left == 2'h2) s_nxt.st = H_UPD;
					else
					begin
						s_nxt.rv = 1'b1;
						s_nxt.err = 1'b0;
						s_nxt.rdata = '0;
						s_nxt.st = H_IDLE;
					end
				end
				else if (s_r.tmo == 4'(mrm_pkg::UPD_TO_CYC - 1))
				begin
					s_nxt.rv = 1'b1;
					s_nxt.err = 1'b1;
					s_nxt.rdata = '0;
					s_nxt.st = H_IDLE;
				end
			end
		endcase
		s_nxt.upd = (s_nxt.st == H_UPD);
		s_nxt.ready = (s_nxt.st == H_IDLE) && !s_nxt.rep;
	end

	always_ff @(posedge mclk)
	begin
		if (!nrst) s_r <= '0;
		else if (ce) s_r <= s_nxt;
	end

	assign bus.addr = s_r.addr;
	assign bus.wdata = s_r.wdata;
	assign bus.rd = s_r.rd;
	assign bus.wr = s_r.wr;
	assign bus.bus16 = s_r.bus16;
	assign bus.datapath_reset_n = s_r.dpn;
	assign bus.perf_update_strobe = s_r.upd;
	assign cmd_ready = s_r.ready;
	assign resp_valid = s_r.rv;
	assign resp_rdata = s_r.rdata;
	assign resp_err = s_r.err;
endmodule

// file: verif/mrm_properties.sv
/*
 Bus and update checker for the register map link.
 Assumes plain interface signals on one clock, mclk.
*/
`timescale 1ns/10ps
module mrm_properties #(
	parameter int NUM_PORTS = 4
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [10:0] addr,
	input wire logic rd,
	input wire logic wr,
	input wire logic [15:0] rdata,
	input wire logic rdy,
	input wire logic perf_update_strobe,
	input wire logic perf_update_status
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	logic stb;
	logic here;
	// Any strobe, and whether the addressed port exists
	assign stb = rd || wr;
	assign here = int'(addr[10:9]) < NUM_PORTS;
	// Update steps: two cycles low, then status back
	sequence busy_s;
		!perf_update_status [*2];
	endsequence
	sequence done_s;
		perf_update_status;
	endsequence
	ready_cause_a:
	assert property (rdy |-> $past(stb))
		else $error("ready without strobe");
	gap_silent_a:
	assert property (stb && addr[10:4] == 7'h02 |=> !rdy)
		else $error("ready in unused gap");
	hole_silent_a:
	assert property (stb && addr[10:6] == 5'h18 |=> !rdy)
		else $error("ready in unused hole");
	absent_port_a:
	assert property (stb && !here && addr[8:6] != 3'h0
		|=> !rdy && rdata == 16'h0000)
		else $error("absent port answered");
	port_ready_a:
	assert property (stb && here && addr[8:6] != 3'h0 |=> rdy)
		else $error("port register gave no ready");
	global_ready_a:
	assert property (stb && addr[10:5] == 6'h00 |=> rdy)
		else $error("global register gave no ready");
	test_ready_a:
	assert property (stb && (addr[10:6] == 5'h08 || addr[10:6] == 5'h10)
		|=> rdy)
		else $error("test register gave no ready");
	update_low_a:
	assert property ($rose(perf_update_strobe) |=> !perf_update_status)
		else $error("status high during update");
	update_order_a:
	assert property ($rose(perf_update_strobe) && perf_update_status
		|=> busy_s ##1 done_s)
		else $error("update steps out of order");
endmodule

// file: verif/multiport_register_map_status_bench.sv
/*
 Bench for host and device ends joined by the link interface.
 Assumes three ports and 4-bit counters so saturation is quick.
*/
`timescale 1ns/10ps
module multiport_register_map_status_bench;
	logic mclk;
	logic nrst;
	logic ce;
	logic [3:0][2:0] port_evt;
	logic [3:0][1:0] cnt_evt;
	logic [3:0][15:0] port_cfg;
	logic zero_count;
	logic cmd_valid;
	logic cmd_write;
	logic [10:0] cmd_addr;
	logic [15:0] cmd_wdata;
	logic bus16_sel;
	logic dp_reset_req;
	logic upd_req;
	logic clr_cnt_req;
	logic cmd_ready;
	logic resp_valid;
	logic [15:0] resp_rdata;
	logic resp_err;
	logic [15:0] q;
	logic e;
	int mismatches;
	int comparisons;
	int seed;
	int k;
	localparam int CW = 4;
	int cfg_m[3];
	// Counter model: live counts, counter registers, alt-mode port
	int live_m[3][2];
	int hold_m[3][2];
	int alt_m;
	logic [10:0] dflt[5] = '{11'h002, 11'h040, 11'h254, 11'h456, 11'h09C};
	logic [10:0] ta[9] = '{11'h020, 11'h030, 11'h080, 11'h1C0, 11'h210,
		11'h5FF, 11'h620, 11'h640, 11'h7FF};
	logic [0:8] te = 9'h107;
	mrm_link_if lnk ();
	mrm_dev #(.NUM_PORTS(3), .CNT_W(CW)) u_mrm_dev (.mclk(mclk), .nrst(nrst),
		.ce(ce), .bus(lnk), .port_evt(port_evt), .cnt_evt(cnt_evt),
		.port_cfg(port_cfg), .zero_count(zero_count));
	mrm_host #(.NUM_PORTS(3)) u_mrm_host (.mclk(mclk), .nrst(nrst),
		.ce(ce), .bus(lnk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
		.cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .bus16_sel(bus16_sel),
		.dp_reset_req(dp_reset_req), .upd_req(upd_req),
		.clr_cnt_req(clr_cnt_req), .cmd_ready(cmd_ready),
		.resp_valid(resp_valid), .resp_rdata(resp_rdata),
		.resp_err(resp_err));
	mrm_properties #(.NUM_PORTS(3)) u_chk (.mclk(mclk), .nrst(nrst),
		.addr(lnk.addr), .rd(lnk.rd), .wr(lnk.wr), .rdata(lnk.rdata),
		.rdy(lnk.rdy), .perf_update_strobe(lnk.perf_update_strobe),
		.perf_update_status(lnk.perf_update_status));
	// Free-running clock
	always #5 mclk = ~mclk;
	task automatic print_verdict;
		if (mismatches == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	// Bounded wait for the host answer
	task automatic wait_resp;
		int n;
		n = 0;
		while (resp_valid !== 1'b1)
		begin
			@(posedge mclk);
			#1;
			n++;
			if (n > 40)
			begin
				mismatches++;
				print_verdict();
			end
		end
		q = resp_rdata;
		e = resp_err;
	endtask
	task automatic cmd(input logic w, input logic [10:0] a,
		input logic [15:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		while (cmd_ready !== 1'b1)
		begin
			@(posedge mclk);
			n++;
			if (n > 40)
			begin
				mismatches++;
				print_verdict();
			end
		end
		cmd_valid <= 1'b1;
		cmd_write <= w;
		cmd_addr <= a;
		cmd_wdata <= d;
		@(posedge mclk);
		cmd_valid <= 1'b0;
		wait_resp();
	endtask
	task automatic rchk(input logic [10:0] a, input logic [15:0] x);
		cmd(1'b0, a, 16'h0000);
		chk(q, x);
	endtask
	// Model of one update: registers take live counts, live clears
	task automatic model_load;
		foreach (hold_m[i, j])
		begin
			hold_m[i][j] = live_m[i][j];
			live_m[i][j] = 0;
		end
	endtask
	// One update, or the two-update counter clear
	task automatic update(input logic two);
		@(posedge mclk);
		upd_req <= !two;
		clr_cnt_req <= two;
		@(posedge mclk);
		upd_req <= 1'b0;
		clr_cnt_req <= 1'b0;
		wait_resp();
		model_load();
		if (two)
			model_load();
	endtask
	task automatic evt(input int p, input int b, input logic v);
		@(posedge mclk);
		port_evt[p][b] <= v;
		repeat (3) @(posedge mclk);
		#1;
	endtask
	task automatic count(input int p, input int c, input int n);
		repeat (n)
		begin
			@(posedge mclk);
			cnt_evt[p][c] <= 1'b1;
			// Saturating; counter 1 frozen in alt mode, all frozen with ce low
			if (ce && live_m[p][c] < 2 ** CW - 1 &&
				!(c == 1 && p == alt_m))
				live_m[p][c]++;
			@(posedge mclk);
			cnt_evt[p][c] <= 1'b0;
		end
	endtask
	task automatic do_reset;
		@(posedge mclk);
		nrst <= 1'b0;
		repeat (10) @(posedge mclk);
		nrst <= 1'b1;
	endtask
	task automatic dp_pulse;
		@(posedge mclk);
		dp_reset_req <= 1'b1;
		repeat (5) @(posedge mclk);
		dp_reset_req <= 1'b0;
		repeat (20) @(posedge mclk);
	endtask
	// Main sequence
	initial
	begin
		mclk = 1'b0;
		nrst = 1'b0;
		ce = 1'b1;
		port_evt = '0;
		cnt_evt = '0;
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_addr = 11'h000;
		cmd_wdata = 16'h0000;
		bus16_sel = 1'b1;
		dp_reset_req = 1'b0;
		upd_req = 1'b0;
		clr_cnt_req = 1'b0;
		mismatches = 0;
		comparisons = 0;
		seed = 32'h74DECF7B;
		alt_m = -1;
		do_reset();
		foreach (dflt[i])
			rchk(dflt[i], 16'h0000);
		chk({15'h0000, zero_count}, 16'h0001);
		foreach (ta[i])
		begin
			cmd(1'b0, ta[i], 16'h0000);
			chk({15'h0000, e}, {15'h0000, te[i]});
			if (!te[i] && ta[i][8:0] >= 9'h040)
				chk(q, 16'h0000);
		end
		cmd(1'b1, 11'h640, 16'hFFFF);
		chk({15'h0000, e}, 16'h0001);
		for (int p = 0; p < 3; p++)
		begin
			cfg_m[p] = $random(seed) & 32'h0000FFFC;
			cmd(1'b1, {2'(p), 9'h040}, 16'(cfg_m[p]));
			rchk({2'(p), 9'h040}, 16'(cfg_m[p]));
			chk(port_cfg[p], 16'(cfg_m[p]));
		end
		@(posedge mclk);
		dp_reset_req <= 1'b1;
		repeat (3) @(posedge mclk);
		cmd(1'b1, 11'h040, 16'hA5A0);
		rchk(11'h040, 16'hA5A0);
		chk(port_cfg[0], 16'(cfg_m[0]));
		@(posedge mclk);
		dp_reset_req <= 1'b0;
		repeat (20) @(posedge mclk);
		evt(0, 0, 1'b1);
		rchk(11'h054, 16'h0001);
		rchk(11'h054, 16'h0000);
		evt(0, 0, 1'b0);
		evt(0, 0, 1'b1);
		rchk(11'h054, 16'h0001);
		evt(0, 2, 1'b1);
		rchk(11'h054, 16'h0004);
		evt(0, 2, 1'b0);
		rchk(11'h054, 16'h0004);
		evt(0, 0, 1'b0);
		evt(0, 0, 1'b1);
		@(posedge mclk);
		bus16_sel <= 1'b0;
		rchk(11'h055, 16'h0000);
		rchk(11'h054, 16'h0001);
		rchk(11'h054, 16'h0000);
		@(posedge mclk);
		bus16_sel <= 1'b1;
		cmd(1'b1, 11'h002, 16'h0004);
		evt(0, 0, 1'b0);
		evt(0, 0, 1'b1);
		evt(0, 2, 1'b1);
		rchk(11'h054, 16'h0005);
		rchk(11'h054, 16'h0005);
		cmd(1'b1, 11'h054, 16'h0001);
		rchk(11'h054, 16'h0004);
		cmd(1'b1, 11'h054, 16'hFFFF);
		rchk(11'h054, 16'h0000);
		evt(0, 0, 1'b0);
		evt(0, 0, 1'b1);
		chk({15'h0000, lnk.irq}, 16'h0000);
		cmd(1'b1, 11'h056, 16'h0001);
		chk({15'h0000, lnk.irq}, 16'h0001);
		cmd(1'b1, 11'h056, 16'h0008);
		rchk(11'h056, 16'h0008);
		chk({15'h0000, lnk.irq}, 16'h0000);
		k = 1 + ($unsigned($random(seed)) % 12);
		count(0, 0, 20);
		count(1, 1, k);
		update(1'b0);
		rchk(11'h09C, 16'h000F);
		rchk(11'h29E, 16'(hold_m[1][1]));
		chk({15'h0000, zero_count}, 16'h0000);
		update(1'b1);
		rchk(11'h29E, 16'(hold_m[1][1]));
		chk({15'h0000, zero_count}, 16'h0001);
		cmd(1'b1, 11'h040, 16'h0002);
		alt_m = 0;
		evt(0, 1, 1'b1);
		rchk(11'h052, 16'h0005);
		rchk(11'h054, 16'h0001);
		count(0, 1, 5);
		count(0, 0, 3);
		update(1'b0);
		rchk(11'h09E, 16'(hold_m[0][1]));
		rchk(11'h09C, 16'(hold_m[0][0]));
		dp_pulse();
		// Mode change then data path reset clears port 0 counters
		hold_m[0] = '{0, 0};
		live_m[0] = '{0, 0};
		rchk(11'h054, 16'h0000);
		rchk(11'h09C, 16'(hold_m[0][0]));
		// Action bit rising outside data path reset starts an update
		count(0, 0, 2);
		cmd(1'b1, 11'h040, 16'h0003);
		model_load();
		rchk(11'h09C, 16'(hold_m[0][0]));
		// Clock enable low: count pulses must be ignored
		@(posedge mclk);
		ce <= 1'b0;
		count(0, 0, 3);
		@(posedge mclk);
		ce <= 1'b1;
		update(1'b0);
		rchk(11'h09C, 16'(hold_m[0][0]));
		do_reset();
		rchk(11'h040, 16'h0000);
		rchk(11'h002, 16'h0000);
		print_verdict();
	end
endmodule
